// ==== rtl/asr_map.vh ====
// register offsets, field positions, reset values and timing counts of the serial receiver
// assumes: included by the receiver modules; 32-bit classic wishbone, byte addresses
`ifndef ASR_MAP_VH
`define ASR_MAP_VH

// ***************
// register offsets
// ***************
`define ASR_OFF_CTRL     8'h00
`define ASR_OFF_STATUS   8'h04
`define ASR_OFF_DATA     8'h08
`define ASR_OFF_DIV      8'h0C
`define ASR_OFF_IRQ_STAT 8'h10
`define ASR_OFF_IRQ_MASK 8'h14

// ***************
// control fields
// ***************
`define ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE    0
`define ASR_CTRL_MODE    1
`define ASR_CTRL_SERIAL_PORT_ENABLE    2
`define ASR_CTRL_RX9     3
`define ASR_CTRL_RESET   4'h0

// ***************
// status fields
// ***************
`define ASR_ST_NINTH     0
`define ASR_ST_FERR      1
`define ASR_ST_OVRN      2
`define ASR_ST_AVAIL     3
`define ASR_ST_ACTIVE    4

// ***************
// interrupt fields
// ***************
`define ASR_IRQ_CHAR     0
`define ASR_IRQ_OVRN     1
`define ASR_IRQ_FERR     2
`define ASR_IRQ_W        3

// ***************
// timing
// ***************
`define ASR_OVERSAMPLE   5'h10
`define ASR_HALF_BIT     4'h7
`define ASR_FULL_BIT     4'hF
`define ASR_DIV_RESET    16'h0001
`define ASR_FIFO_DEPTH   2

`endif

// ==== rtl/asr_baud_gen.v ====
// baud generator: one-cycle tick at sixteen times the baud rate
// assumes: divisor from software, tick every divisor+1 clocks; stopped while run is low
`timescale 1ns/1ps
module asr_baud_gen (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// control
	input  wire        run_i,
	input  wire [15:0] divisor_i,
	// tick
	output reg         tick_o
);
	reg [15:0] count;

	always @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			count  <= 16'h0000;
			tick_o <= 1'b0;
		end else if (count >= divisor_i) begin
			count  <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			count  <= count + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule // asr_baud_gen

// ==== rtl/asr_fifo.v ====
// two-entry receive store: character, ninth bit and framing error travel together
// assumes: a push while full is dropped; a pop while empty is ignored
`timescale 1ns/1ps
`include "asr_map.vh"
module asr_fifo (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        flush_i,
	// write side
	input  wire        push_i,
	input  wire [9:0]  push_data_i,
	output wire        full_o,
	// read side
	input  wire        pop_i,
	output wire [9:0]  head_o,
	output wire        empty_o
);
	reg [9:0] mem [0:`ASR_FIFO_DEPTH-1];
	reg       wr_ptr;
	reg       rd_ptr;
	reg [1:0] level;

	assign full_o  = (level == 2'h2);
	assign empty_o = (level == 2'h0);
	assign head_o  = mem[rd_ptr];

	always @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			level  <= 2'h0;
		end else begin
			if (push_i && !full_o) begin
				mem[wr_ptr] <= push_data_i;
				wr_ptr      <= ~wr_ptr;
			end
			if (pop_i && !empty_o)
				rd_ptr <= ~rd_ptr;
			if ((push_i && !full_o) && !(pop_i && !empty_o))
				level <= level + 2'h1;
			else if (!(push_i && !full_o) && (pop_i && !empty_o))
				level <= level - 2'h1;
		end
	end
endmodule // asr_fifo

// ==== rtl/asr_receiver.v ====
// asynchronous serial receiver with classic wishbone register slave
// assumes: rx pin asynchronous to clk_i; one 200 MHz clock; synchronous reset
//
// How it works
// - sixteen-times oversampling, shifter advances per bit
// - two-entry store holds finished characters
// - data read returns and removes oldest
// - receive only with enable, async mode, port on
// - falling edge in idle starts character
// - mid start bit high: drop silently
// - full bit to each centre, majority vote
// - stop bit zero sets framing error
// - finished character stored, receive flag set
// - overrun when full blocks further reception
// - eight or nine data bits supported
// - clearing either enable clears overrun, restarts
// - ninth bit enable; ninth bit separate field
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "asr_map.vh"
module asr_receiver (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// serial line
	input  wire        receive_data_pin_i,
	// interrupt
	output reg         irq_o
);
	// ***************
	// states
	// ***************
	localparam ST_IDLE  = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_DATA  = 2'h2;
	localparam ST_STOP  = 2'h3;

	// majority of three samples
	function maj3;
		input [2:0] s;
		begin
			maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
		end
	endfunction

	// ***************
	// registers
	// ***************
	reg [3:0]  ctrl;
	reg [15:0] divisor;
	reg [2:0]  irq_stat;
	reg [2:0]  irq_mask;
	reg        overrun;

	reg        rx_meta;
	reg        rx_sync;
	reg        rx_prev;
	reg [1:0]  state;
	reg [3:0]  tick_cnt;
	reg [3:0]  bit_cnt;
	reg [8:0]  receive_shift_reg;
	reg [1:0]  votes;

	wire continuous_receive_enable = ctrl[`ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE];
	wire link_mode_sync            = ctrl[`ASR_CTRL_MODE];
	wire serial_port_enable        = ctrl[`ASR_CTRL_SERIAL_PORT_ENABLE];
	wire ninth_bit_rx_enable       = ctrl[`ASR_CTRL_RX9];
	// pin direction and analog select are handled outside this block
	wire rx_active = continuous_receive_enable && !link_mode_sync && serial_port_enable;
	wire [3:0] data_bits = ninth_bit_rx_enable ? 4'h9 : 4'h8;

	wire       tick;
	wire       fifo_full;
	wire       fifo_empty;
	wire [9:0] fifo_head;
	reg        push;
	reg  [9:0] push_data;

	wire bus_req   = cyc_i && stb_i && !ack_o;
	wire wr_ctrl   = bus_req && we_i && sel_i[0] && (adr_i == `ASR_OFF_CTRL);
	wire wr_div    = bus_req && we_i && (adr_i == `ASR_OFF_DIV);
	wire wr_istat  = bus_req && we_i && sel_i[0] && (adr_i == `ASR_OFF_IRQ_STAT);
	wire wr_imask  = bus_req && we_i && sel_i[0] && (adr_i == `ASR_OFF_IRQ_MASK);
	wire rd_data   = bus_req && !we_i && (adr_i == `ASR_OFF_DATA);

	asr_baud_gen u_baud (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (rx_active),
		.divisor_i (divisor),
		.tick_o    (tick)
	);

	asr_fifo u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (!rx_active),
		.push_i      (push),
		.push_data_i (push_data),
		.full_o      (fifo_full),
		.pop_i       (rd_data),
		.head_o      (fifo_head),
		.empty_o     (fifo_empty)
	);

	// ***************
	// line synchroniser
	// ***************
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_meta <= receive_data_pin_i;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	// ***************
	// data recovery
	// ***************
	always @(posedge clk_i) begin
		push      <= 1'b0;
		push_data <= 10'h000;
		if (rst_i || !rx_active) begin
			state             <= ST_IDLE;
			tick_cnt          <= 4'h0;
			bit_cnt           <= 4'h0;
			receive_shift_reg <= 9'h000;
			votes             <= 2'h0;
		end else begin
			case (state)
			ST_IDLE: begin
				// overrun holds the receiver until an enable is dropped
				if (!overrun && rx_prev && !rx_sync) begin
					state    <= ST_START;
					tick_cnt <= 4'h0;
				end
			end
			ST_START: begin
				if (tick) begin
					tick_cnt <= tick_cnt + 4'h1;
					if (tick_cnt == `ASR_HALF_BIT) begin
						tick_cnt <= 4'h0;
						bit_cnt  <= 4'h0;
						if (rx_sync)
							state <= ST_IDLE;
						else
							state <= ST_DATA;
					end
				end
			end
			ST_DATA, ST_STOP: begin
				if (tick) begin
					tick_cnt <= tick_cnt + 4'h1;
					// three votes on the last three ticks, the last one at the bit centre
					if (tick_cnt == 4'hD)
						votes[1] <= rx_sync;
					if (tick_cnt == 4'hE)
						votes[0] <= rx_sync;
					if (tick_cnt == `ASR_FULL_BIT) begin
						tick_cnt <= 4'h0;
						if (state == ST_DATA) begin
							// shift right, lsb first; ninth bit lands in bit 8
							receive_shift_reg <= {maj3({votes[1], votes[0], rx_sync}),
								receive_shift_reg[8:1]};
							bit_cnt <= bit_cnt + 4'h1;
							if (bit_cnt == data_bits - 4'h1)
								state <= ST_STOP;
						end else begin
							state     <= ST_IDLE;
							push      <= 1'b1;
							push_data <= {~maj3({votes[1], votes[0], rx_sync}),
								ninth_bit_rx_enable ? receive_shift_reg
								: {1'b0, receive_shift_reg[8:1]}};
						end
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ***************
	// registers and events
	// ***************
	wire ev_char = push && !fifo_full;
	wire ev_ovrn = push && fifo_full;
	wire ev_ferr = ev_char && push_data[9];

	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= `ASR_CTRL_RESET;
			divisor  <= `ASR_DIV_RESET;
			irq_mask <= 3'h0;
			irq_stat <= 3'h0;
			overrun  <= 1'b0;
			ack_o    <= 1'b0;
			dat_o    <= 32'h00000000;
			irq_o    <= 1'b0;
		end else begin
			ack_o <= bus_req;
			if (wr_ctrl)
				ctrl <= dat_i[3:0];
			if (wr_div) begin
				if (sel_i[0])
					divisor[7:0] <= dat_i[7:0];
				if (sel_i[1])
					divisor[15:8] <= dat_i[15:8];
			end
			if (wr_imask)
				irq_mask <= dat_i[2:0];
			if (!rx_active)
				overrun <= 1'b0;
			else if (ev_ovrn)
				overrun <= 1'b1;
			// set wins over write-one-to-clear
			irq_stat <= (irq_stat & ~(wr_istat ? dat_i[2:0] : 3'h0)) | {ev_ferr, ev_ovrn, ev_char};
			irq_o    <= |(irq_stat & irq_mask);
			dat_o    <= 32'h00000000;
			if (bus_req && !we_i) begin
				if (adr_i == `ASR_OFF_CTRL)
					dat_o <= {28'h0000000, ctrl};
				else if (adr_i == `ASR_OFF_STATUS)
					dat_o <= {27'h0000000, (state != ST_IDLE), !fifo_empty, overrun,
						fifo_head[9] & !fifo_empty, fifo_head[8] & !fifo_empty};
				else if (adr_i == `ASR_OFF_DATA)
					dat_o <= fifo_empty ? 32'h00000000 : {24'h000000, fifo_head[7:0]};
				else if (adr_i == `ASR_OFF_DIV)
					dat_o <= {16'h0000, divisor};
				else if (adr_i == `ASR_OFF_IRQ_STAT)
					dat_o <= {29'h00000000, irq_stat};
				else if (adr_i == `ASR_OFF_IRQ_MASK)
					dat_o <= {29'h00000000, irq_mask};
			end
		end
	end
endmodule // asr_receiver

// ==== verification/asr_tx_model.sv ====
// far-side serial transmitter: 8N1 or 9N1 frames, lsb first
// assumes: baud divisor 0, so one bit lasts 16 clocks
`timescale 1ns/1ps
module asr_tx_model (
	// clock
	input  wire clk_i,
	// serial line
	output reg  line_o
);
	// idle line stands high between frames
	initial line_o = 1'b1;
	task send(input [8:0] d, input integer n, input stop);
		integer i;
		begin
			@(posedge clk_i) line_o <= 1'b0;
			repeat (16) @(posedge clk_i);
			for (i = 0; i < n; i = i + 1) begin
				line_o <= d[i];
				repeat (16) @(posedge clk_i);
			end
			line_o <= stop;
			repeat (16) @(posedge clk_i);
			line_o <= 1'b1;
		end
	endtask
	// start pulse far shorter than half a bit
	task glitch;
		begin
			@(posedge clk_i) line_o <= 1'b0;
			repeat (4) @(posedge clk_i);
			line_o <= 1'b1;
			repeat (200) @(posedge clk_i);
		end
	endtask
endmodule // asr_tx_model

// ==== verification/asr_receiver_monitor.sv ====
// bus and interrupt checks on the receiver's ports
// assumes: bench holds cyc/stb until ack and idles a cycle between requests
`timescale 1ns/1ps
module asr_receiver_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [7:0]  adr_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	AST_ACK_ONE: assert property (s_take |=> ack_o) else $error("ack late");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
	AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o)) else $error("stray ack");
	AST_DAT_ZERO: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
	AST_UNMAPPED: assert property (s_take ##0 (!we_i && adr_i == 8'h1C) ##1 ack_o |-> dat_o == 32'h0)
		else $error("unmapped read");
	AST_RST_QUIET: assert property ($fell(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0)
		else $error("reset state");
	AST_MASKED: assert property (s_take ##0 (we_i && adr_i == 8'h14 && dat_i[2:0] == 3'h0) |-> ##3 !irq_o)
		else $error("masked irq");
	AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(cyc_i && we_i, 1) || $past(cyc_i && we_i, 2))
		else $error("irq fell alone");
endmodule // asr_receiver_chk
bind asr_receiver asr_receiver_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

// ==== verification/asr_receiver_tb_top.sv ====
// self-checking bench: wishbone master tasks plus serial transmitter model
// assumes: 200 MHz clock, divisor set to 0 (16 clocks per bit)
`timescale 1ns/1ps
module asr_receiver_tb_top;
	reg         clk_i;
	reg         rst_i = 1'b1;
	reg         cyc = 1'b0;
	reg         stb = 1'b0;
	reg         we = 1'b0;
	reg  [7:0]  adr = 8'h00;
	reg  [31:0] dat = 32'h0;
	reg  [31:0] q;
	wire [31:0] dat_o;
	wire        ack_o;
	wire        irq_o;
	wire        line;
	integer     errors = 0;
	integer     checks_done = 0;
	integer     cycles = 0;
	asr_receiver dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .receive_data_pin_i(line), .irq_o(irq_o));
	asr_tx_model tx (.clk_i(clk_i), .line_o(line));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// whole run needs about 1900 cycles
	always @(posedge clk_i) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			wrap_up;
		end
	end
	// ****************
	// bus and compare
	// ****************
	task wb(input w, input [7:0] a, input [31:0] d);
		integer t;
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			dat <= d;
			t = 0;
			@(posedge clk_i);
			while (ack_o !== 1'b1 && t < 50) begin
				t = t + 1;
				@(posedge clk_i);
			end
			if (t >= 50)
				errors = errors + 1;
			q = dat_o;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	task chk(input [31:0] e, input [31:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("[FAIL] %0t exp %h got %h", $time, e, g);
			end
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			wb(1'b0, a, 32'h0);
			chk(e, q);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		wb(1'b1, a, d);
	endtask
	// ****************
	// scenarios
	// ****************
	task t_reset;
		begin
			rd(8'h00, 32'h0);
			rd(8'h0C, 32'h1);
			rd(8'h14, 32'h0);
			rd(8'h1C, 32'h0);
			wr(8'h0C, 32'h0);
			$display("reset test done");
		end
	endtask
	task t_off;
		begin
			wr(8'h00, 32'h7);
			tx.send(9'h055, 8, 1'b1);
			rd(8'h04, 32'h0);
			wr(8'h00, 32'h1);
			tx.send(9'h055, 8, 1'b1);
			rd(8'h04, 32'h0);
			$display("disable test done");
		end
	endtask
	task t_basic;
		begin
			wr(8'h14, 32'h7);
			wr(8'h00, 32'h5);
			tx.send(9'h0A5, 8, 1'b1);
			tx.send(9'h03C, 8, 1'b0);
			repeat (20) @(posedge clk_i);
			rd(8'h04, 32'h8);
			chk(32'h1, {31'h0, irq_o});
			rd(8'h08, 32'hA5);
			rd(8'h04, 32'hA);
			rd(8'h08, 32'h3C);
			rd(8'h08, 32'h0);
			rd(8'h10, 32'h5);
			wr(8'h10, 32'h7);
			rd(8'h10, 32'h0);
			chk(32'h0, {31'h0, irq_o});
			$display("receive test done");
		end
	endtask
	task t_glitch;
		begin
			tx.glitch;
			rd(8'h04, 32'h0);
			rd(8'h10, 32'h0);
			$display("glitch test done");
		end
	endtask
	task t_over;
		begin
			tx.send(9'h011, 8, 1'b1);
			tx.send(9'h022, 8, 1'b1);
			tx.send(9'h033, 8, 1'b1);
			repeat (20) @(posedge clk_i);
			rd(8'h04, 32'hC);
			rd(8'h10, 32'h3);
			tx.send(9'h044, 8, 1'b1);
			repeat (20) @(posedge clk_i);
			rd(8'h08, 32'h11);
			rd(8'h08, 32'h22);
			rd(8'h04, 32'h4);
			wr(8'h00, 32'h4);
			rd(8'h04, 32'h0);
			wr(8'h10, 32'h7);
			$display("overrun test done");
		end
	endtask
	task t_nine;
		begin
			wr(8'h00, 32'hD);
			tx.send(9'h1C3, 9, 1'b1);
			repeat (20) @(posedge clk_i);
			rd(8'h04, 32'h9);
			rd(8'h08, 32'hC3);
			wr(8'h14, 32'h0);
			repeat (4) @(posedge clk_i);
			chk(32'h0, {31'h0, irq_o});
			rd(8'h10, 32'h1);
			$display("ninth bit test done");
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d errors %0d", checks_done, errors);
			if (errors == 0 && checks_done > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_off;
		t_basic;
		t_glitch;
		t_over;
		t_nine;
		wrap_up;
	end
endmodule // asr_receiver_tb_top
